// ---- flash_security_vector_guard.sv ----
// Flash security vector fetch, protection decode and checksum control
`timescale 1ns/1ps
// Notes on behaviour
// R01: Fetch first guard word at 0x248000, second at 0x248008; a boot word follows each (0x248004, 0x24800C).
// R02: Guard1 bit 16 set blocks flash reads except in internal-vector boot mode.
// R03: Bit 17 set with bit 18 clear enforces write protection in every mode.
// R04: Bits 17 and 18 both set enforce write protection except internal-vector boot.
// R05: Guard1 low sixteen bits are per-sector locks for the 8 KB sectors; code decodes only bits 7:0 (SMALL_SECTORS = 8).
// R06: Locks count only with bit 17 set; bit n locks sector n; 0 locks.
// R07: Programmer must clear lock bit 4 so the vector holding sector stays locked.
// R08: Guard2 bit n locks large sector n+8 when bit 17 set; 0 locks.
// R09: Vectors fetched after reset; parallel programming accepted only once done.
// R10: Programmer waits at least 2.76 ms after supply comes up.
// R11: Programmer waits at least 1.0 ms after init reset release.
// R12: Checksum engine sums 32-bit words over a chosen flash address range.
// R13: Checksum paced by slow oscillator clock, 2 MHz by default.
// R14: Core bus clock must stay faster than the oscillator clock at start.
// R15: Decoded protection latched after fetch, held until next reset; code latches the guard words, decode follows live mode pins.
module flash_security_vector_guard
    import guard_pkg::*;
(
    input  wire logic                   clk_sys,
    input  wire logic                   rst_n,
    // Wishbone classic slave
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [7:0]             wb_adr_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic [31:0]            wb_dat_i,
    output logic [31:0]                 wb_dat_o,
    output logic                        wb_ack_o,
    // Flash read port
    output logic                        fl_req_o,
    output logic [23:0]                 fl_addr_o,
    input  wire logic [31:0]            fl_rdata_i,
    input  wire logic                   fl_rvalid_i,
    // Mode pins and protection outputs
    input  wire logic [2:0]             mode_select_pins,
    output logic                        vectors_valid,
    output logic                        prog_access_ready,
    output logic                        read_block,
    output logic                        write_block,
    output logic [SMALL_SECTORS-1:0]    small_sector_lock,
    output logic [LARGE_SECTORS-1:0]    large_sector_lock
);
    import guard_pkg::*;

    // Vector fetch state and latched guard words
    fetch_state_t fetch_q;
    logic [31:0]  first_flash_guard_word_q;
    logic [31:0]  second_flash_guard_word_q;

    // Checksum control registers
    logic [7:0]   cks_div_q;
    logic [23:0]  cks_start_q;
    logic [23:0]  cks_end_q;
    logic         cks_done_flag_q;
    logic [7:0]   tick_cnt_q;

    // Protection outputs, registered
    logic                       read_block_q;
    logic                       write_block_q;
    logic [SMALL_SECTORS-1:0]   small_lock_q;
    logic [LARGE_SECTORS-1:0]   large_lock_q;

    // Bus slave
    logic         ack_q;
    logic [31:0]  rdata_q;

    // Checksum engine wiring
    flash_rd_if   cks_rd ();
    logic         cks_busy;
    logic         cks_done;
    logic [31:0]  cks_result;

    // Flash port: the fetch owns it until both vectors are in
    wire fetching    = (fetch_q != FETCH_DONE);
    wire fetch_req   = fetching;
    wire [23:0] fetch_addr = (fetch_q == FETCH_FIRST) ? GUARD1_ADDR : GUARD2_ADDR; // R01

    assign fl_req_o     = fetching ? fetch_req  : cks_rd.req;
    assign fl_addr_o    = fetching ? fetch_addr : cks_rd.addr;
    assign cks_rd.rdata = fl_rdata_i;
    assign cks_rd.valid = fl_rvalid_i & ~fetching;

    wire fetch_take = fetching & fl_rvalid_i;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fetch_q <= FETCH_FIRST;
        end else if (fetch_take) begin
            fetch_q <= (fetch_q == FETCH_FIRST) ? FETCH_SECOND : FETCH_DONE; // R01
        end
    end

    // Guard words are only ever loaded by the fetch
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            first_flash_guard_word_q  <= 32'h00000000;
            second_flash_guard_word_q <= 32'h00000000;
        end else if (fetch_take) begin
            if (fetch_q == FETCH_FIRST)
                first_flash_guard_word_q  <= fl_rdata_i; // R15
            else
                second_flash_guard_word_q <= fl_rdata_i; // R15
        end
    end

    // Protection decode
    wire internal_vector_boot_mode = (mode_select_pins == MODE_INTERNAL_VECTOR_BOOT_MODE);
    wire par_prog_mode             = (mode_select_pins == MODE_PAR_PROG);

    wire read_prot  = first_flash_guard_word_q[READ_PROT_BIT];
    wire write_prot = first_flash_guard_word_q[WRITE_PROT_BIT];
    wire prot_level = first_flash_guard_word_q[PROT_LEVEL_BIT];

    wire read_block_d  = ~fetching & read_prot & ~internal_vector_boot_mode; // R02
    // Level clear: no exception; level set: boot mode exempt
    wire write_block_d = ~fetching & write_prot
                         & ~(prot_level & internal_vector_boot_mode); // R03 R04

    wire [SMALL_SECTORS-1:0] small_lock_d =
        {SMALL_SECTORS{write_block_d}}
        & ~first_flash_guard_word_q[SMALL_SECTORS-1:0]; // R05 R06
    wire [LARGE_SECTORS-1:0] large_lock_d =
        {LARGE_SECTORS{write_block_d}} & ~second_flash_guard_word_q; // R08

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            read_block_q  <= 1'b0;
            write_block_q <= 1'b0;
            small_lock_q  <= '0;
            large_lock_q  <= '0;
        end else begin
            read_block_q  <= read_block_d;
            write_block_q <= write_block_d;
            small_lock_q  <= small_lock_d;
            large_lock_q  <= large_lock_d;
        end
    end

    assign vectors_valid     = ~fetching;
    assign prog_access_ready = ~fetching & par_prog_mode; // R09
    assign read_block        = read_block_q;
    assign write_block       = write_block_q;
    assign small_sector_lock = small_lock_q;
    assign large_sector_lock = large_lock_q;

    // Wishbone classic slave, ack one cycle after the request
    wire        bus_req  = wb_cyc_i & wb_stb_i & ~ack_q;
    wire        wr_stb   = wb_cyc_i & wb_stb_i & ack_q & wb_we_i;
    wire        hit_ctrl  = (wb_adr_i == REG_CKS_CTRL);
    wire        hit_start = (wb_adr_i == REG_CKS_START);
    wire        hit_end   = (wb_adr_i == REG_CKS_END);

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0]  sel);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) res[8*b +: 8] = new_v[8*b +: 8];
        end
        return res;
    endfunction

    wire [31:0] ctrl_view   = {16'h0000, cks_div_q, 7'h00, cks_busy};
    wire [31:0] ctrl_merged = merge_bytes(ctrl_view, wb_dat_i, wb_sel_i);
    wire [31:0] start_merged = merge_bytes({8'h00, cks_start_q}, wb_dat_i, wb_sel_i);
    wire [31:0] end_merged   = merge_bytes({8'h00, cks_end_q}, wb_dat_i, wb_sel_i);

    // A start while busy or before the vectors are in is ignored
    wire cks_start = wr_stb & hit_ctrl & wb_sel_i[0] & wb_dat_i[CTRL_START_BIT]
                     & ~fetching & ~cks_busy;
    wire done_clear = wr_stb & (wb_adr_i == REG_STATUS) & wb_sel_i[0]
                      & wb_dat_i[ST_CKS_DONE];

    wire [31:0] status_view = {26'h0000000,
                               prog_access_ready,
                               cks_done_flag_q,
                               cks_busy,
                               write_block_q,
                               read_block_q,
                               ~fetching};

    logic [31:0] rd_mux;
    always_comb begin
        unique case (wb_adr_i)
            REG_STATUS:     rd_mux = status_view;
            REG_GUARD1:     rd_mux = first_flash_guard_word_q;
            REG_GUARD2:     rd_mux = second_flash_guard_word_q;
            REG_CKS_CTRL:   rd_mux = ctrl_view;
            REG_CKS_START:  rd_mux = {8'h00, cks_start_q};
            REG_CKS_END:    rd_mux = {8'h00, cks_end_q};
            REG_CKS_RESULT: rd_mux = cks_result;
            default:        rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            ack_q <= bus_req;
            if (bus_req) rdata_q <= rd_mux;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;

    // Software-written checksum settings
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cks_div_q   <= CKS_DIV_RST;
            cks_start_q <= CKS_ADDR_RST;
            cks_end_q   <= CKS_ADDR_RST;
        end else if (wr_stb) begin
            // Keep the slow clock at most half the bus clock
            if (hit_ctrl)
                cks_div_q <= (ctrl_merged[CTRL_DIV_LSB +: 8] < CKS_DIV_MIN)
                             ? CKS_DIV_MIN : ctrl_merged[CTRL_DIV_LSB +: 8]; // R14
            if (hit_start) cks_start_q <= start_merged[23:0];
            if (hit_end)   cks_end_q   <= end_merged[23:0];
        end
    end

    // Sticky completion flag; a new completion beats a clear
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            cks_done_flag_q <= 1'b0;
        else if (cks_done)
            cks_done_flag_q <= 1'b1;
        else if (done_clear)
            cks_done_flag_q <= 1'b0;
    end

    // Slow oscillator enable: one pulse every cks_div_q+1 cycles
    wire rc_tick = (tick_cnt_q == 8'h00);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            tick_cnt_q <= CKS_DIV_RST;
        else if (rc_tick)
            tick_cnt_q <= cks_div_q; // R13
        else
            tick_cnt_q <= tick_cnt_q - 8'h01;
    end

    checksum_engine u_checksum (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .tick       (rc_tick),
        .start      (cks_start),
        .start_addr (cks_start_q),
        .end_addr   (cks_end_q),
        .busy       (cks_busy),
        .done       (cks_done),
        .result     (cks_result),
        .rd         (cks_rd)
    );

endmodule

// ---- guard_pkg.sv ----
// Shared constants and types for the flash security vector guard
package guard_pkg;

    // Flash port geometry
    localparam int              FLASH_ADDR_W  = 24;
    localparam int              WORD_W        = 32;
    localparam logic [23:0]     WORD_STEP     = 24'h000004;

    // Guard word locations; a boot word follows each guard word and is not fetched
    localparam logic [23:0]     GUARD1_ADDR   = 24'h248000;
    localparam logic [23:0]     BOOT1_ADDR    = 24'h248004;
    localparam logic [23:0]     GUARD2_ADDR   = 24'h248008;
    localparam logic [23:0]     BOOT2_ADDR    = 24'h24800C;

    // Fields of the guard words
    localparam int              READ_PROT_BIT  = 16;
    localparam int              WRITE_PROT_BIT = 17;
    localparam int              PROT_LEVEL_BIT = 18;
    localparam int              SMALL_SECTORS  = 8;
    localparam int              LARGE_SECTORS  = 32;
    localparam int              FIRST_LARGE    = 8;
    localparam int              HOLDING_SECTOR = 4;

    // Mode pin codes
    localparam logic [2:0]      MODE_INTERNAL_VECTOR_BOOT_MODE    = 3'h0;
    localparam logic [2:0]      MODE_PAR_PROG  = 3'h7;

    // Register offsets (byte addresses)
    localparam logic [7:0]      REG_STATUS     = 8'h00;
    localparam logic [7:0]      REG_GUARD1     = 8'h04;
    localparam logic [7:0]      REG_GUARD2     = 8'h08;
    localparam logic [7:0]      REG_CKS_CTRL   = 8'h0C;
    localparam logic [7:0]      REG_CKS_START  = 8'h10;
    localparam logic [7:0]      REG_CKS_END    = 8'h14;
    localparam logic [7:0]      REG_CKS_RESULT = 8'h18;

    // Status bits
    localparam int              ST_VALID       = 0;
    localparam int              ST_READ_BLOCK  = 1;
    localparam int              ST_WRITE_BLOCK = 2;
    localparam int              ST_CKS_BUSY    = 3;
    localparam int              ST_CKS_DONE    = 4;
    localparam int              ST_PROG_READY  = 5;

    // Control fields
    localparam int              CTRL_START_BIT = 0;
    localparam int              CTRL_DIV_LSB   = 8;

    // Checksum pacing clock, derived from the system clock
    localparam int              SYS_CLK_MHZ    = 250;
    localparam int              RC_TARGET_MHZ  = 2;
    localparam logic [7:0]      CKS_DIV_RST    = 8'(SYS_CLK_MHZ / RC_TARGET_MHZ - 1);
    localparam logic [7:0]      CKS_DIV_MIN    = 8'h01;
    localparam logic [23:0]     CKS_ADDR_RST   = 24'h000000;

    typedef enum logic [1:0] {FETCH_FIRST, FETCH_SECOND, FETCH_DONE} fetch_state_t;
    typedef enum logic [1:0] {CK_IDLE, CK_WAIT_TICK, CK_READ} cks_state_t;

endpackage

// ---- flash_rd_if.sv ----
// Internal flash read channel between a requester and the port arbiter
`timescale 1ns/1ps
interface flash_rd_if;
    logic        req;
    logic [23:0] addr;
    logic [31:0] rdata;
    logic        valid;

    modport requester (output req, output addr, input rdata, input valid);
    modport server    (input req, input addr, output rdata, output valid);
endinterface

// ---- checksum_engine.sv ----
// 32-bit flash checksum engine paced by the slow oscillator enable
`timescale 1ns/1ps
module checksum_engine
    import guard_pkg::*;
(
    input  wire logic                   clk_sys,
    input  wire logic                   rst_n,
    input  wire logic                   tick,
    input  wire logic                   start,
    input  wire logic [23:0]            start_addr,
    input  wire logic [23:0]            end_addr,
    output logic                        busy,
    output logic                        done,
    output logic [31:0]                 result,
    flash_rd_if.requester               rd
);
    import guard_pkg::*;

    cks_state_t  state_q;
    logic [23:0] addr_q;
    logic [31:0] sum_q;
    logic        done_q;
    logic [31:0] result_q;

    wire         last_word = (addr_q >= end_addr);
    wire  [31:0] sum_next  = sum_q + rd.rdata;

    assign rd.req  = (state_q == CK_READ);
    assign rd.addr = addr_q;
    assign busy    = (state_q != CK_IDLE);
    assign done    = done_q;
    assign result  = result_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q  <= CK_IDLE;
            addr_q   <= CKS_ADDR_RST;
            sum_q    <= 32'h00000000;
            done_q   <= 1'b0;
            result_q <= 32'h00000000;
        end else begin
            done_q <= 1'b0;
            unique case (state_q)
                CK_IDLE: begin
                    if (start) begin
                        addr_q  <= start_addr;
                        sum_q   <= 32'h00000000;
                        state_q <= CK_WAIT_TICK;
                    end
                end
                CK_WAIT_TICK: begin
                    // One word per slow-clock period
                    if (tick) state_q <= CK_READ; // R13
                end
                CK_READ: begin
                    if (rd.valid) begin
                        sum_q <= sum_next; // R12
                        if (last_word) begin
                            result_q <= sum_next;
                            done_q   <= 1'b1;
                            state_q  <= CK_IDLE;
                        end else begin
                            addr_q  <= addr_q + WORD_STEP;
                            state_q <= CK_WAIT_TICK;
                        end
                    end
                end
            endcase
        end
    end
endmodule

// ---- guard_monitor.sv ----
// Port-level checker for the flash security vector guard
`timescale 1ns/1ps
module guard_monitor
(
    input  wire logic                                  clk_sys,
    input  wire logic                                  rst_n,
    input  wire logic                                  wb_cyc_i,
    input  wire logic                                  wb_stb_i,
    input  wire logic                                  wb_ack_o,
    input  wire logic                                  fl_req_o,
    input  wire logic [23:0]                           fl_addr_o,
    input  wire logic [31:0]                           fl_rdata_i,
    input  wire logic                                  fl_rvalid_i,
    input  wire logic [2:0]                            mode_select_pins,
    input  wire logic                                  vectors_valid,
    input  wire logic                                  prog_access_ready,
    input  wire logic                                  read_block,
    input  wire logic                                  write_block,
    input  wire logic [guard_pkg::SMALL_SECTORS-1:0]   small_sector_lock,
    input  wire logic [guard_pkg::LARGE_SECTORS-1:0]   large_sector_lock
);
    import guard_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic [31:0] g1_q;
    logic [31:0] g2_q;
    wire         fetch_hit = fl_rvalid_i && fl_req_o && !vectors_valid;
    // Shadow copies of the fetched guard words
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            g1_q <= 32'h0;
            g2_q <= 32'h0;
        end else begin
            g1_q <= (fetch_hit && fl_addr_o == GUARD1_ADDR) ? fl_rdata_i : g1_q;
            g2_q <= (fetch_hit && fl_addr_o == GUARD2_ADDR) ? fl_rdata_i : g2_q;
        end
    end
    property p_fetch_addr;
        !vectors_valid && fl_req_o |-> fl_addr_o == GUARD1_ADDR || fl_addr_o == GUARD2_ADDR;
    endproperty
    a_fetch_addr: assert property (p_fetch_addr) else $error("bad fetch address");
    property p_fetch_order;
        fetch_hit && fl_addr_o == GUARD1_ADDR |=> fl_addr_o == GUARD2_ADDR && !vectors_valid;
    endproperty
    a_fetch_order: assert property (p_fetch_order) else $error("fetch order");
    property p_done;
        fetch_hit && fl_addr_o == GUARD2_ADDR |=> vectors_valid;
    endproperty
    a_done: assert property (p_done) else $error("fetch not completed");
    property p_ready;
        prog_access_ready == (vectors_valid && mode_select_pins == MODE_PAR_PROG);
    endproperty
    a_ready: assert property (p_ready) else $error("programming ready wrong");
    property p_quiet;
        !vectors_valid |-> !read_block && !write_block && large_sector_lock == 32'h0;
    endproperty
    a_quiet: assert property (p_quiet) else $error("protection before fetch");
    property p_read;
        vectors_valid && $past(vectors_valid)
            |-> read_block == (g1_q[16] && $past(mode_select_pins) != MODE_INTERNAL_VECTOR_BOOT_MODE);
    endproperty
    a_read: assert property (p_read) else $error("read block decode");
    property p_write;
        vectors_valid && $past(vectors_valid)
            |-> write_block == (g1_q[17] && !(g1_q[18] && $past(mode_select_pins) == 3'h0));
    endproperty
    a_write: assert property (p_write) else $error("write block decode");
    property p_small;
        vectors_valid && $past(vectors_valid)
            |-> small_sector_lock == (write_block ? ~g1_q[7:0] : 8'h0);
    endproperty
    a_small: assert property (p_small) else $error("small lock decode");
    property p_large;
        vectors_valid && $past(vectors_valid) |-> large_sector_lock == (write_block ? ~g2_q : 32'h0);
    endproperty
    a_large: assert property (p_large) else $error("large lock decode");
    property p_latch;
        vectors_valid && $past(vectors_valid) && $stable(mode_select_pins)
            |=> vectors_valid && $stable(read_block) && $stable(write_block)
                && $stable(large_sector_lock);
    endproperty
    a_latch: assert property (p_latch) else $error("decode not held");
    property p_ack;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("bus ack timing");
endmodule

// ---- flash_model.sv ----
// Flash array stand-in answering guard fetches and checksum reads
`timescale 1ns/1ps
module flash_model
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        req,
    input  wire logic [23:0] addr,
    input  wire logic [31:0] guard1,
    input  wire logic [31:0] guard2,
    input  wire logic [3:0]  latency,
    output logic [31:0]      rdata,
    output logic             rvalid
);
    import guard_pkg::*;
    logic [3:0]  wait_q;
    wire  [31:0] word_d = (addr == GUARD1_ADDR) ? guard1 :
                          (addr == GUARD2_ADDR) ? guard2 : {8'hA5, addr};
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wait_q <= 4'h0;
            rvalid <= 1'b0;
            rdata  <= 32'h0;
        end else if (req && !rvalid && wait_q >= latency) begin
            wait_q <= 4'h0;
            rvalid <= 1'b1;
            rdata  <= word_d;
        end else begin
            wait_q <= (req && !rvalid) ? wait_q + 4'h1 : 4'h0;
            rvalid <= 1'b0;
            rdata  <= ~rdata; // Data not held once released
        end
    end
endmodule

// ---- test_flash_security_vector_guard.sv ----
// Self-checking bench for the flash security vector guard
`timescale 1ns/1ps
module test_flash_security_vector_guard;
    import guard_pkg::*;
    logic        clk_sys, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, fl_req_o, fl_rvalid_i;
    logic        vectors_valid, prog_access_ready, read_block, write_block;
    logic [7:0]  wb_adr_i, small_sector_lock;
    logic [3:0]  wb_sel_i, latency;
    logic [2:0]  mode_select_pins;
    logic [23:0] fl_addr_o;
    logic [31:0] wb_dat_i, wb_dat_o, fl_rdata_i, large_sector_lock, guard1, guard2, rd;
    int          failures, cmp_count, cycles;

    flash_security_vector_guard i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fl_req_o(fl_req_o),
        .fl_addr_o(fl_addr_o), .fl_rdata_i(fl_rdata_i), .fl_rvalid_i(fl_rvalid_i),
        .mode_select_pins(mode_select_pins), .vectors_valid(vectors_valid),
        .prog_access_ready(prog_access_ready), .read_block(read_block),
        .write_block(write_block), .small_sector_lock(small_sector_lock),
        .large_sector_lock(large_sector_lock));
    flash_model i_flash (.clk_sys(clk_sys), .rst_n(rst_n), .req(fl_req_o), .addr(fl_addr_o),
        .guard1(guard1), .guard2(guard2), .latency(latency), .rdata(fl_rdata_i),
        .rvalid(fl_rvalid_i));

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("Counts: %0d compares, %0d mismatches", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            report_and_stop();
        end
    end

    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                           input logic [3:0] sel);
        int n;
        n = 0;
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= sel;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack_o !== 1'b1);
        check(n, 32'h2, "ack one cycle after request");
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    // Reset, let the guard words be fetched, then judge the decode
    task automatic t_boot(input logic [31:0] g1, input logic [31:0] g2, input logic [2:0] mode,
                          input logic [3:0] lat);
        logic wp;
        logic rb;
        logic pp;
        int   n;
        wp = g1[17] && !(g1[18] && mode == MODE_INTERNAL_VECTOR_BOOT_MODE);
        rb = g1[16] && mode != MODE_INTERNAL_VECTOR_BOOT_MODE;
        pp = mode == MODE_PAR_PROG;
        n = 0;
        @(posedge clk_sys);
        guard1 <= g1;
        guard2 <= g2;
        mode_select_pins <= mode;
        latency <= lat;
        rst_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        while (vectors_valid !== 1'b1 && n < 100) begin
            @(posedge clk_sys);
            n++;
        end
        repeat (2) @(posedge clk_sys);
        #1;
        check(read_block, rb, "read block");
        check(write_block, wp, "write block");
        check(small_sector_lock, wp ? 8'(~g1[7:0]) : 8'h0, "small locks");
        check(large_sector_lock, wp ? ~g2 : 32'h0, "large locks");
        check(prog_access_ready, pp, "programming ready");
        wb_xfer(1'b0, REG_GUARD1, 32'h0, 4'h0);
        check(rd, g1, "first guard word");
        wb_xfer(1'b0, REG_GUARD2, 32'h0, 4'h0);
        check(rd, g2, "second guard word");
        wb_xfer(1'b0, REG_STATUS, 32'h0, 4'h0);
        check(rd[5:0], {pp, 2'b00, wp, rb, 1'b1}, "status");
        $display("boot case mode %0d done", mode);
    endtask

    task automatic t_regs;
        wb_xfer(1'b0, REG_CKS_CTRL, 32'h0, 4'h0);
        check(rd[15:0], 16'h7C00, "divider reset");
        wb_xfer(1'b0, 8'h1C, 32'h0, 4'h0);
        check(rd, 32'h0, "unmapped read");
        wb_xfer(1'b1, REG_GUARD1, 32'h0, 4'hF);
        wb_xfer(1'b0, REG_GUARD1, 32'h0, 4'h0);
        check(rd, guard1, "guard word read only");
        wb_xfer(1'b1, REG_CKS_END, 32'hFFFFFFFF, 4'h1);
        wb_xfer(1'b0, REG_CKS_END, 32'h0, 4'h0);
        check(rd, 32'h000000FF, "byte select");
        $display("register test done");
    endtask

    task automatic t_checksum;
        logic [31:0] sum;
        int          n;
        sum = 32'h0;
        n = 0;
        for (int a = 'h100; a <= 'h108; a += 4) sum += {8'hA5, 24'(a)};
        wb_xfer(1'b1, REG_CKS_START, 32'h000100, 4'hF);
        wb_xfer(1'b1, REG_CKS_END, 32'h000108, 4'hF);
        wb_xfer(1'b1, REG_CKS_CTRL, 32'h00000301, 4'hF);
        do begin
            wb_xfer(1'b0, REG_STATUS, 32'h0, 4'h0);
            n++;
        end while (rd[ST_CKS_DONE] !== 1'b1 && n < 200);
        wb_xfer(1'b0, REG_CKS_RESULT, 32'h0, 4'h0);
        check(rd, sum, "checksum");
        wb_xfer(1'b1, REG_STATUS, 32'h00000010, 4'hF);
        wb_xfer(1'b0, REG_STATUS, 32'h0, 4'h0);
        check(rd[ST_CKS_DONE], 1'b0, "done cleared");
        check({read_block, write_block}, 2'b11, "decode held");
        $display("checksum test done");
    endtask

    initial begin
        rst_n = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        guard1 = 32'h0;
        guard2 = 32'h0;
        latency = 4'h0;
        mode_select_pins = 3'h7;
        // Guard words below keep lock bit 4 clear
        t_boot(32'h0001FFEF, 32'hFFFFFFFF, 3'h7, 4'h0);
        t_boot(32'h000200EF, 32'hFFFF0000, 3'h0, 4'h5);
        t_boot(32'h0007004A, 32'h12345678, 3'h0, 4'h2);
        t_boot(32'h0007004A, 32'h0F0F00FF, 3'h7, 4'h1);
        t_regs();
        t_checksum();
        report_and_stop();
    end
endmodule

bind flash_security_vector_guard guard_monitor i_mon (.clk_sys(clk_sys), .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .fl_req_o(fl_req_o),
    .fl_addr_o(fl_addr_o), .fl_rdata_i(fl_rdata_i), .fl_rvalid_i(fl_rvalid_i),
    .mode_select_pins(mode_select_pins), .vectors_valid(vectors_valid),
    .prog_access_ready(prog_access_ready), .read_block(read_block),
    .write_block(write_block), .small_sector_lock(small_sector_lock),
    .large_sector_lock(large_sector_lock));
